// ===== verilog/se_regs.svh
// Purpose: named constants for the status and address decode block
// Assumes: included by bare name
// Notes: definitions only
`ifndef SE_REGS_SVH
`define SE_REGS_SVH

`define ST_OK 8'h00
`define ST_MISCMP 8'h01
`define ST_PARSE 8'h03
`define ST_ECC 8'h05
`define ST_SELFTEST 8'h07
`define ST_HEALTH 8'h08
`define ST_EXEC 8'h0f
`define ST_WAKE 8'h11
`define ST_WDT 8'hee
`define ST_COMM 8'hff

`define GRP_MIN 8'h04
`define GRP_MAX 8'h9b
`define STATUS_GRP_LEN 8'h04
`define GRP_OVERHEAD 8'h03
`define CRC_BYTES 8'h02
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h0000
`define IDLE_BYTE 8'hff

`define IDX_COUNT 8'h00
`define IDX_OPCODE 8'h01
`define IDX_P1 8'h02
`define IDX_ADDR_LO 8'h03
`define IDX_ADDR_HI 8'h04

`define ZONE_CFG 2'h0
`define ZONE_OTP 2'h1
`define ZONE_DATA 2'h2
`define ZONE_BAD 2'h3
`define P1_UNIT32 7
`define P1_ENC 6
`define P1_ZONE_HI 1
`define P1_ZONE_LO 0
`define DIR_READ 0

`define A_SLOT_HI 6
`define A_SLOT_LO 3
`define A_OFF_HI 2
`define A_OFF_LO 0
`define A_CFG_BLK_HI 4
`define A_CFG_BLK_LO 3
`define A_OTP_BLK 3
`define A_SMALL_BLK 8
`define A_S8_BLK_HI 11
`define A_S8_BLK_LO 8
`define A_BIG_BLK_HI 9
`define A_BIG_BLK_LO 8

`define SLOT_SMALL_LAST 4'h7
`define SLOT_EIGHT 4'h8
`define S8_LAST_BLK 4'hc
`define BIG_LAST_BLK 2'h2
`define BIG_LAST_OFF 3'h1
`define OFF_FIRST 3'h0

`define WR_PLAIN_MASK 16'ha300
`define WR_ENC_MASK 16'h0060
`define RD_MASK 16'hfd00

`endif

// ===== verilog/se_pkg.sv
// Purpose: types shared by the status and address decode block
// Assumes: constants live in se_regs.svh
// Notes: none
package se_pkg;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_RX = 3'b001,
		B_EVAL = 3'b010,
		B_BUSY = 3'b011,
		B_HDR = 3'b100,
		B_DATA = 3'b101,
		B_CRCL = 3'b110,
		B_CRCH = 3'b111
	} build_st_t;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_DIR = 2'b01,
		L_WRITE = 2'b10,
		L_READ = 2'b11
	} link_st_t;

	typedef enum logic [2:0] {
		R_OK = 3'b000,
		R_MISCMP = 3'b001,
		R_ECC = 3'b010,
		R_SELFTEST = 3'b011,
		R_HEALTH = 3'b100,
		R_EXEC = 3'b101
	} res_code_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] param1;
		logic [15:0] addr;
	} cmd_t;

	typedef struct packed {
		logic [1:0] zone;
		logic [3:0] slot;
		logic [3:0] block;
		logic [2:0] offset;
		logic unit32;
	} dec_t;

	typedef struct packed {
		res_code_t code;
		logic [7:0] res_len;
	} exec_res_t;

endpackage

// ===== verilog/resp_fifo.sv
// Purpose: response byte FIFO between group builder and serial transmitter
// Assumes: depth is a power of two
// Notes: flush empties it in one cycle
`timescale 1ns/10ps
module resp_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	generate
		if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad
			$error("resp_fifo: depth must be a power of two of at least 2");
		end
	endgenerate

	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_r != (AW+1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rd_r];

	always_ff @(posedge mclk) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n || flush) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // resp_fifo

// ===== verilog/se_status_decode.sv
// Purpose: group receive, checksum, address decode, access policy and status groups
// Assumes: serial link pins are asynchronous to mclk; executor sits outside
// Notes: results stream from the executor through the response FIFO
//
// How it works
// - every answer is count, packet, two-byte checksum
// - nothing readable until whole input group arrived
// - checksum failure reported before any other fault
// - success 0x00, mac_check_command/verify mismatch 0x01
// - illegal memory zone, address or parameter gives 0x03
// - elliptic-curve fault gives 0x05, retry allowed
// - self-test failure latches, reports 0x07 until cleared
// - health failure reports 0x08, blocks random commands
// - cannot run in present state gives 0x0F
// - after wake, status 0x11 waits in output
// - too little time-limit time left gives 0xEE
// - communication failure gives 0xFF, nothing executed
// - configuration zone in 4 or 32 bytes only
// - configuration uses address bits 4:3 and 2:0
// - configuration and OTP zones are read-only
// - OTP 64 bytes, bit 3 block, 2:0 word
// - plain writes 8,9,13,15; encrypted writes 5,6
// - plain reads 8,10-15; everything else refused
// - slot bits 6:3, offset 2:0, block per slot
// - slots 0-7 block 1 only offset 0; 32-byte access passes at any offset
// - count byte 4 to 155, else I/O error
// - CRC-16 poly 0x8005, zero start, LSB first
// - busy during execution, link ignored, nothing offered
`timescale 1ns/10ps
`include "se_regs.svh"
module se_status_decode #(
	parameter logic [7:0] READ_OP = 8'h02,
	parameter logic [7:0] WRITE_OP = 8'h12,
	parameter logic [7:0] RNG_OP = 8'h1b,
	parameter int unsigned WDT_CYCLES = 26000000,
	parameter int unsigned CMD_MAX_CYCLES = 4000000,
	parameter int FIFO_W = 8,
	parameter int FIFO_D = 32
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic wake,
	input wire logic idle_sleep,
	input wire logic selftest_fail,
	input wire logic selftest_clear,
	input wire logic health_clear,
	output logic cmd_valid,
	output se_pkg::cmd_t cmd,
	output se_pkg::dec_t cmd_dec,
	input wire logic exec_done,
	input wire se_pkg::exec_res_t exec_res,
	input wire logic res_valid,
	input wire logic [7:0] res_data,
	output logic res_ready,
	output logic busy
);
	generate
		if (CMD_MAX_CYCLES == 0 || CMD_MAX_CYCLES >= WDT_CYCLES || FIFO_W != 8) begin : g_bad
			$error("se_status_decode: bad timer limits or fifo width");
		end
	endgenerate

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = d[i] ^ r[15];
			r = {r[14:0], 1'b0};
			if (fb)
				r = r ^ `CRC_POLY;
		end
		return r;
	endfunction

	// link pin synchronisers and edge detection
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= scl;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end
	wire scl_rise = scl_s2 && !scl_s3;
	wire scl_fall = !scl_s2 && scl_s3;
	wire bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	wire bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

	se_pkg::build_st_t bst_r;
	se_pkg::link_st_t lst_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic oe_n_r;
	logic rx_v_r;
	logic [7:0] rx_byte_r;

	// fifo wiring
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
	logic [7:0] f_in_data, f_out_data;

	wire link_ignore = bst_r != se_pkg::B_IDLE && bst_r != se_pkg::B_RX;
	wire read_ok = f_out_valid && bst_r != se_pkg::B_RX;
	wire tx_load = lst_r == se_pkg::L_READ && scl_fall && bit_cnt_r == 3'h0;
	wire [7:0] rx_full = {rx_sh_r[6:0], sda_s2};
	assign f_out_ready = tx_load && read_ok;
	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_r;

	always_ff @(posedge mclk) begin
		if (!reset_n || link_ignore) begin
			lst_r <= se_pkg::L_IDLE;
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 8'h00;
			tx_sh_r <= `IDLE_BYTE;
			oe_n_r <= 1'b1;
			rx_v_r <= 1'b0;
			rx_byte_r <= 8'h00;
		end else begin
			rx_v_r <= 1'b0;
			if (bus_start) begin
				lst_r <= se_pkg::L_DIR;
				bit_cnt_r <= 3'h0;
				oe_n_r <= 1'b1;
			end else if (bus_stop) begin
				lst_r <= se_pkg::L_IDLE;
				oe_n_r <= 1'b1;
			end else if (scl_rise && lst_r != se_pkg::L_IDLE) begin
				rx_sh_r <= rx_full;
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7 && lst_r == se_pkg::L_DIR)
					lst_r <= rx_full[`DIR_READ] ? se_pkg::L_READ : se_pkg::L_WRITE;
				if (bit_cnt_r == 3'h7 && lst_r == se_pkg::L_WRITE) begin
					rx_v_r <= 1'b1;
					rx_byte_r <= rx_full;
				end
			end else if (tx_load) begin
				tx_sh_r <= read_ok ? f_out_data : `IDLE_BYTE;
				oe_n_r <= read_ok ? f_out_data[7] : 1'b1;
			end else if (scl_fall && lst_r == se_pkg::L_READ) begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b1};
				oe_n_r <= tx_sh_r[6];
			end
		end
	end

	// group receive state
	logic [7:0] rx_idx_r, rx_cnt_r, crc_lo_r, code_r, resp_len_r, out_idx_r;
	logic [15:0] crc_r;
	logic comm_err_r, stream_r, cmd_valid_r, selftest_r, health_r;
	se_pkg::cmd_t cmd_r;
	se_pkg::dec_t dec_r;
	logic [31:0] wdt_cnt_r;

	wire cnt_bad = rx_byte_r < `GRP_MIN || rx_byte_r > `GRP_MAX;
	wire in_crc_area = rx_idx_r < rx_cnt_r - `CRC_BYTES;
	wire is_crc_lo = rx_idx_r == rx_cnt_r - `CRC_BYTES;
	wire is_last = rx_idx_r == rx_cnt_r - 8'h01;
	wire crc_match = {rx_byte_r, crc_lo_r} == crc_r;

	// address decode
	wire [1:0] zone = cmd_r.param1[`P1_ZONE_HI:`P1_ZONE_LO];
	wire unit32 = cmd_r.param1[`P1_UNIT32];
	wire enc = cmd_r.param1[`P1_ENC];
	wire [3:0] slot = cmd_r.addr[`A_SLOT_HI:`A_SLOT_LO];
	wire [2:0] offs = cmd_r.addr[`A_OFF_HI:`A_OFF_LO];
	wire [1:0] cfg_blk = cmd_r.addr[`A_CFG_BLK_HI:`A_CFG_BLK_LO];
	wire otp_blk = cmd_r.addr[`A_OTP_BLK];
	wire small_blk = cmd_r.addr[`A_SMALL_BLK];
	wire [3:0] s8_blk = cmd_r.addr[`A_S8_BLK_HI:`A_S8_BLK_LO];
	wire [1:0] big_blk = cmd_r.addr[`A_BIG_BLK_HI:`A_BIG_BLK_LO];
	wire is_small = slot <= `SLOT_SMALL_LAST;
	wire is_eight = slot == `SLOT_EIGHT;
	wire small_ok = !small_blk || unit32 || offs == `OFF_FIRST;
	wire eight_ok = s8_blk <= `S8_LAST_BLK;
	wire big_ok = big_blk < `BIG_LAST_BLK ||
		(big_blk == `BIG_LAST_BLK && (unit32 || offs <= `BIG_LAST_OFF));
	wire word_ok = is_small ? small_ok : (is_eight ? eight_ok : big_ok);
	wire is_rd = cmd_r.opcode == READ_OP;
	wire is_wr = cmd_r.opcode == WRITE_OP;
	wire is_mem = is_rd || is_wr;
	wire is_data = zone == `ZONE_DATA;
	wire [15:0] perm = is_wr ? (enc ? `WR_ENC_MASK : `WR_PLAIN_MASK) : `RD_MASK;
	wire parse_err = is_mem && (zone == `ZONE_BAD || (is_wr && !is_data) ||
		(is_data && !word_ok));
	wire policy_err = is_mem && is_data && !perm[slot];
	wire wdt_low = wdt_cnt_r > 32'(WDT_CYCLES - CMD_MAX_CYCLES);
	wire rng_blocked = health_r && cmd_r.opcode == RNG_OP;

	se_pkg::dec_t dec_w;
	always_comb begin
		dec_w.zone = zone;
		dec_w.slot = is_data ? slot : 4'h0;
		dec_w.offset = offs;
		dec_w.unit32 = unit32;
		if (zone == `ZONE_CFG)
			dec_w.block = {2'b00, cfg_blk};
		else if (zone == `ZONE_OTP)
			dec_w.block = {3'b000, otp_blk};
		else if (is_small)
			dec_w.block = {3'b000, small_blk};
		else if (is_eight)
			dec_w.block = s8_blk;
		else
			dec_w.block = {2'b00, big_blk};
	end

	logic [7:0] exec_code;
	always_comb begin
		case (exec_res.code)
			se_pkg::R_OK: exec_code = `ST_OK;
			se_pkg::R_MISCMP: exec_code = `ST_MISCMP;
			se_pkg::R_ECC: exec_code = `ST_ECC;
			se_pkg::R_SELFTEST: exec_code = `ST_SELFTEST;
			se_pkg::R_HEALTH: exec_code = `ST_HEALTH;
			se_pkg::R_EXEC: exec_code = `ST_EXEC;
			default: exec_code = `ST_EXEC;
		endcase
	end

	// response builder feed into fifo
	wire st_data = bst_r == se_pkg::B_DATA;
	wire data_src_v = !stream_r || res_valid;
	assign f_in_valid = bst_r == se_pkg::B_HDR || bst_r == se_pkg::B_CRCL ||
		bst_r == se_pkg::B_CRCH || (st_data && data_src_v);
	assign f_in_data = bst_r == se_pkg::B_HDR ? resp_len_r :
		bst_r == se_pkg::B_CRCL ? crc_r[7:0] :
		bst_r == se_pkg::B_CRCH ? crc_r[15:8] :
		stream_r ? res_data : code_r;
	assign res_ready = st_data && stream_r && f_in_ready;
	wire pushed = f_in_valid && f_in_ready;
	wire pkt_last = out_idx_r == resp_len_r - `GRP_OVERHEAD - 8'h01;
	assign f_flush = bst_r == se_pkg::B_IDLE && (rx_v_r || wake);
	assign busy = link_ignore;
	assign cmd_valid = cmd_valid_r;
	assign cmd = cmd_r;
	assign cmd_dec = dec_r;

	resp_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.flush(f_flush),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// command time-limit timer, restarted by wake or idle/sleep
	always_ff @(posedge mclk) begin
		if (!reset_n || wake || idle_sleep)
			wdt_cnt_r <= 32'h0;
		else if (wdt_cnt_r < 32'(WDT_CYCLES))
			wdt_cnt_r <= wdt_cnt_r + 32'h1;
	end

	// sticky failure flags; a set wins over a clear
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			selftest_r <= 1'b0;
			health_r <= 1'b0;
		end else begin
			if (selftest_fail || (bst_r == se_pkg::B_BUSY && exec_done &&
				exec_res.code == se_pkg::R_SELFTEST))
				selftest_r <= 1'b1;
			else if (selftest_clear)
				selftest_r <= 1'b0;
			if (bst_r == se_pkg::B_BUSY && exec_done && exec_res.code == se_pkg::R_HEALTH)
				health_r <= 1'b1;
			else if (health_clear)
				health_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bst_r <= se_pkg::B_IDLE;
			rx_idx_r <= 8'h00;
			rx_cnt_r <= 8'h00;
			crc_lo_r <= 8'h00;
			crc_r <= `CRC_INIT;
			comm_err_r <= 1'b0;
			code_r <= `ST_OK;
			resp_len_r <= `STATUS_GRP_LEN;
			out_idx_r <= 8'h00;
			stream_r <= 1'b0;
			cmd_valid_r <= 1'b0;
			cmd_r <= '0;
			dec_r <= '0;
		end else begin
			cmd_valid_r <= 1'b0;
			case (bst_r)
				se_pkg::B_IDLE: begin
					if (wake) begin
						code_r <= `ST_WAKE;
						stream_r <= 1'b0;
						resp_len_r <= `STATUS_GRP_LEN;
						crc_r <= `CRC_INIT;
						bst_r <= se_pkg::B_HDR;
					end else if (rx_v_r) begin
						rx_cnt_r <= rx_byte_r;
						rx_idx_r <= 8'h01;
						comm_err_r <= cnt_bad;
						crc_r <= crc_byte(`CRC_INIT, rx_byte_r);
						bst_r <= se_pkg::B_RX;
					end
				end
				se_pkg::B_RX: begin
					if (comm_err_r && bus_stop)
						bst_r <= se_pkg::B_EVAL;
					else if (rx_v_r && !comm_err_r) begin
						rx_idx_r <= rx_idx_r + 8'h01;
						if (in_crc_area)
							crc_r <= crc_byte(crc_r, rx_byte_r);
						if (is_crc_lo)
							crc_lo_r <= rx_byte_r;
						if (rx_idx_r == `IDX_OPCODE)
							cmd_r.opcode <= rx_byte_r;
						if (rx_idx_r == `IDX_P1)
							cmd_r.param1 <= rx_byte_r;
						if (rx_idx_r == `IDX_ADDR_LO)
							cmd_r.addr[7:0] <= rx_byte_r;
						if (rx_idx_r == `IDX_ADDR_HI)
							cmd_r.addr[15:8] <= rx_byte_r;
						if (is_last) begin
							comm_err_r <= !crc_match;
							bst_r <= se_pkg::B_EVAL;
						end
					end
				end
				se_pkg::B_EVAL: begin
					stream_r <= 1'b0;
					resp_len_r <= `STATUS_GRP_LEN;
					crc_r <= `CRC_INIT;
					bst_r <= se_pkg::B_HDR;
					if (comm_err_r)
						code_r <= `ST_COMM;
					else if (parse_err)
						code_r <= `ST_PARSE;
					else if (policy_err)
						code_r <= `ST_EXEC;
					else if (wdt_low)
						code_r <= `ST_WDT;
					else if (selftest_r)
						code_r <= `ST_SELFTEST;
					else if (rng_blocked)
						code_r <= `ST_HEALTH;
					else begin
						dec_r <= dec_w;
						cmd_valid_r <= 1'b1;
						bst_r <= se_pkg::B_BUSY;
					end
				end
				se_pkg::B_BUSY: begin
					if (exec_done) begin
						code_r <= exec_code;
						stream_r <= exec_res.code == se_pkg::R_OK && exec_res.res_len != 8'h00;
						resp_len_r <= (exec_res.code == se_pkg::R_OK && exec_res.res_len != 8'h00) ?
							exec_res.res_len + `GRP_OVERHEAD : `STATUS_GRP_LEN;
						crc_r <= `CRC_INIT;
						bst_r <= se_pkg::B_HDR;
					end
				end
				se_pkg::B_HDR: begin
					if (pushed) begin
						crc_r <= crc_byte(crc_r, f_in_data);
						out_idx_r <= 8'h00;
						bst_r <= se_pkg::B_DATA;
					end
				end
				se_pkg::B_DATA: begin
					if (pushed) begin
						crc_r <= crc_byte(crc_r, f_in_data);
						out_idx_r <= out_idx_r + 8'h01;
						if (pkt_last)
							bst_r <= se_pkg::B_CRCL;
					end
				end
				se_pkg::B_CRCL: begin
					if (pushed)
						bst_r <= se_pkg::B_CRCH;
				end
				se_pkg::B_CRCH: begin
					if (pushed)
						bst_r <= se_pkg::B_IDLE;
				end
				default: bst_r <= se_pkg::B_IDLE;
			endcase
		end
	end
endmodule // se_status_decode

// ===== dv/se_status_decode_checker.sv
// Purpose: port assertions for the status and address decode block
// Assumes: bound into se_status_decode, single mclk domain
// Notes: memory opcodes come from the block's own parameters
`timescale 1ns/10ps
module se_status_decode_checker #(
	parameter logic [7:0] READ_OP = 8'h02,
	parameter logic [7:0] WRITE_OP = 8'h12
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic sda_oe_n,
	input wire logic cmd_valid,
	input wire se_pkg::cmd_t cmd,
	input wire se_pkg::dec_t cmd_dec,
	input wire logic res_ready,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	localparam logic [15:0] plain_wr = 16'ha300;
	localparam logic [15:0] enc_wr = 16'h0060;
	localparam logic [15:0] plain_rd = 16'hfd00;
	wire logic mem_op = cmd_valid && (cmd.opcode == READ_OP || cmd.opcode == WRITE_OP);
	wire logic wr_op = mem_op && cmd.opcode == WRITE_OP;
	wire logic data_z = cmd_dec.zone == 2'h2;
	wire logic [3:0] s = cmd_dec.slot;
	property p_exec_busy; cmd_valid |-> busy ##1 busy; endproperty
	a_exec_busy: assert property (p_exec_busy) else $error("command issued while not busy");
	property p_quiet; busy |-> sda_oe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("data line driven while busy");
	property p_fill; res_ready |-> busy && !cmd_valid; endproperty
	a_fill: assert property (p_fill) else $error("result taken outside execution");
	property p_stable; cmd_valid |=> $stable(cmd) [*4]; endproperty
	a_stable: assert property (p_stable) else $error("command changed while executing");
	property p_zone; mem_op |-> cmd_dec.zone == cmd.param1[1:0] && cmd_dec.zone != 2'h3
		&& cmd_dec.unit32 == cmd.param1[7]; endproperty
	a_zone: assert property (p_zone) else $error("illegal zone or unit executed");
	property p_ro; wr_op |-> data_z; endproperty
	a_ro: assert property (p_ro) else $error("write to read-only zone executed");
	property p_wr_slot; wr_op |-> (cmd.param1[6] ? enc_wr[s] : plain_wr[s]); endproperty
	a_wr_slot: assert property (p_wr_slot) else $error("forbidden slot write executed");
	property p_rd_slot; mem_op && !wr_op && data_z |-> plain_rd[s]; endproperty
	a_rd_slot: assert property (p_rd_slot) else $error("forbidden slot read executed");
	property p_data_dec; mem_op && data_z |-> s == cmd.addr[6:3] && cmd_dec.offset == cmd.addr[2:0]
		&& cmd_dec.block == (s <= 4'h7 ? {3'h0, cmd.addr[8]} : s == 4'h8 ? cmd.addr[11:8]
		: {2'h0, cmd.addr[9:8]}); endproperty
	a_data_dec: assert property (p_data_dec) else $error("data address decode wrong");
	property p_cfg_dec; mem_op && cmd_dec.zone == 2'h0 |-> cmd_dec.block == {2'h0, cmd.addr[4:3]}
		&& cmd_dec.offset == cmd.addr[2:0]; endproperty
	a_cfg_dec: assert property (p_cfg_dec) else $error("config address decode wrong");
	property p_otp_dec; mem_op && cmd_dec.zone == 2'h1 |-> cmd_dec.block == {3'h0, cmd.addr[3]}
		&& cmd_dec.offset == cmd.addr[2:0]; endproperty
	a_otp_dec: assert property (p_otp_dec) else $error("otp address decode wrong");
	property p_small; mem_op && data_z && s <= 4'h7 && !cmd_dec.unit32 && cmd_dec.block != 4'h0
		|-> cmd_dec.block == 4'h1 && cmd_dec.offset == 3'h0; endproperty
	a_small: assert property (p_small) else $error("invalid small slot word executed");
	c_exec: cover property (cmd_valid ##[1:40] res_ready);
	c_drive: cover property (!sda_oe_n);
	c_write: cover property (wr_op && cmd.param1[6]);
endmodule // se_status_decode_checker
bind se_status_decode se_status_decode_checker #(.READ_OP(READ_OP), .WRITE_OP(WRITE_OP)) chk (
	.mclk(mclk), .reset_n(reset_n), .sda_oe_n(sda_oe_n), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_dec(cmd_dec), .res_ready(res_ready), .busy(busy));

// ===== dv/host_link_model.sv
// Purpose: host master on the serial link
// Assumes: data line has a pull-up; link clock idles high between frames
// Notes: data changes mid low phase so it never looks like start or stop
`timescale 1ns/10ps
module host_link_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	localparam int HALF = 200;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end
	task automatic start();
		#HALF sda_low = 1'b1;
		#HALF scl = 1'b0;
	endtask
	task automatic stop();
		#(HALF / 2) sda_low = 1'b1;
		#(HALF / 2) scl = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF;
	endtask
	task automatic wr_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#(HALF / 2) sda_low = !b[i];
			#(HALF / 2) scl = 1'b1;
			#HALF scl = 1'b0;
		end
	endtask
	task automatic send(input logic [7:0] q[$]);
		start();
		wr_byte(8'h00);
		foreach (q[i]) wr_byte(q[i]);
		stop();
	endtask
	task automatic read(input int n);
		start();
		wr_byte(8'h01);
		repeat (n) begin
			for (int i = 7; i >= 0; i--) begin
				#HALF scl = 1'b1;
				#(HALF / 2) rx_byte[i] = sda;
				#(HALF / 2) scl = 1'b0;
			end
			rx_stb = 1'b1;
			rx_stb <= #1 1'b0;
		end
		stop();
	endtask
endmodule // host_link_model

// ===== dv/se_status_decode_test.sv
// Purpose: self-checking bench for the status and address decode block
// Assumes: executor modelled here, host on the link in host_link_model
// Notes: timer shortened to 8000 cycles with 2000 reserved per command
`timescale 1ns/10ps
module se_status_decode_test;
	localparam logic [7:0] RD = 8'h02;
	localparam logic [7:0] WR = 8'h12;
	localparam logic [7:0] RNG = 8'h1b;
	logic mclk = 1'b0, reset_n = 1'b0, wake = 1'b0, idle_sleep = 1'b0, selftest_fail = 1'b0;
	logic selftest_clear = 1'b0, health_clear = 1'b0, exec_done = 1'b0, res_valid = 1'b0;
	logic [7:0] res_data = 8'h00;
	se_pkg::exec_res_t exec_res = '0;
	logic scl, sda_low, sda_out, sda_oe_n, cmd_valid, res_ready, busy, rx_stb, peek = 0, no_rst = 0;
	logic [7:0] rx_byte;
	se_pkg::cmd_t cmd;
	int fail_count = 0, total_checks = 0, exec_dly = 3, split = 0;
	logic [7:0] eq[$], dq[$];
	se_pkg::cmd_t cq[$];
	se_pkg::exec_res_t rq[$];
	logic [7:0] st_tab[6] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h08, 8'h0f};
	wire logic sda = !(sda_low || (!sda_oe_n && !sda_out));
	always #25 mclk = !mclk;
	host_link_model host (.scl(scl), .sda_low(sda_low), .sda(sda), .rx_byte(rx_byte),
		.rx_stb(rx_stb));
	se_status_decode #(.WDT_CYCLES(8000), .CMD_MAX_CYCLES(2000)) dut (.mclk(mclk),
		.reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.wake(wake), .idle_sleep(idle_sleep), .selftest_fail(selftest_fail),
		.selftest_clear(selftest_clear), .health_clear(health_clear), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_dec(), .exec_done(exec_done), .exec_res(exec_res),
		.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .busy(busy));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk) s = 1'b1;
		@(negedge mclk) s = 1'b0;
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c = 16'h0000;
		foreach (q[i]) for (int b = 0; b < 8; b++)
			c = {c[14:0], 1'b0} ^ ((q[i][b] ^ c[15]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction
	function automatic int push_grp(input logic [7:0] p[$]);
		logic [15:0] c;
		p.push_front(8'(p.size() + 3));
		c = crc16(p);
		eq = {eq, p, c[7:0], c[15:8]};
		return p.size() + 2;
	endfunction
	task automatic txn(input logic [7:0] cnt, op, p1, input logic [15:0] a, input logic [7:0] st,
		input bit run = 1'b0, input int len = 0, input bit bad = 1'b0);
		logic [7:0] g[$];
		logic [7:0] p[$];
		logic [15:0] c;
		int n;
		g = {cnt, op, p1, a[7:0], a[15:8]};
		c = crc16(g) ^ {15'h0000, bad};
		g = {g, c[7:0], c[15:8]};
		if (run) begin
			rq.push_back({se_pkg::res_code_t'(st[2:0]), 8'(len)});
			cq.push_back({op, p1, a});
			repeat (len) p.push_back(8'($urandom));
			dq = {dq, p};
		end
		if (!run || st != 0 || len == 0) p = {run ? st_tab[st[2:0]] : st};
		if (peek || split) eq.push_back(8'hff);
		n = push_grp(p);
		if (!no_rst) pulse(idle_sleep);
		if (split) begin
			host.send(g[0:2]);
			host.read(1);
			host.send(g[3:$]);
		end else host.send(g);
		if (peek) host.read(1);
		repeat (4) @(negedge mclk);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge mclk);
		host.read(n);
	endtask
	always @(posedge rx_stb) chk("resp", eq.size() > 0 ? eq.pop_front() : 8'hxx, rx_byte);
	always @(negedge mclk) if (cmd_valid === 1'b1)
		chk("cmd", cq.size() > 0 ? cq.pop_front() : 32'hx, cmd);
	initial forever begin
		@(negedge mclk);
		if (cmd_valid === 1'b1) begin
			exec_res = rq.size() > 0 ? rq.pop_front() : {se_pkg::R_EXEC, 8'h00};
			repeat (exec_dly) @(negedge mclk);
			pulse(exec_done);
			if (exec_res.code == se_pkg::R_OK) repeat (exec_res.res_len) begin
				res_data = dq.pop_front();
				res_valid = 1'b1;
				#1;
				while (res_ready !== 1'b1) @(negedge mclk) #1;
				@(negedge mclk);
			end
			res_valid = 1'b0;
		end
	end
	initial begin
		repeat (95000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end
	initial begin
		int s, k, n;
		bit ok;
		n = $urandom(51260);
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		pulse(wake);
		n = push_grp({8'h11});
		host.read(n);
		$display("done wake");
		txn(8'h07, RD, 8'h80, 16'($urandom), 8'h00, 1, 29);
		txn(8'h07, RD, 8'h01, 16'($urandom), 8'h00, 1, 1 + $urandom % 8);
		$display("done zones");
		for (s = 0; s < 16; s++) for (k = 0; k < 3; k++) begin
			ok = k == 0 ? (s == 8 || s >= 10) : k == 1 ? s inside {8, 9, 13, 15} : s inside {5, 6};
			txn(8'h07, k == 0 ? RD : WR, k == 2 ? 8'hc2 : 8'h82, 16'(s << 3),
				ok ? 8'((s + k) % 6) : 8'h0f, ok);
			// executor self-test and health codes latch the failure flags
			if (ok) begin
				pulse(selftest_clear);
				pulse(health_clear);
			end
		end
		$display("done policy");
		txn(8'h07, RD, 8'h03, 16'h0000, 8'h03);
		txn(8'h07, WR, 8'h80, 16'h0000, 8'h03);
		txn(8'h07, WR, 8'h81, 16'h0000, 8'h03);
		txn(8'h07, WR, 8'h42, 16'h0129, 8'h03);
		txn(8'h07, WR, 8'h42, 16'h0128, 8'h00, 1);
		txn(8'h07, RD, 8'h02, 16'h0d40, 8'h03);
		txn(8'h07, RD, 8'h02, 16'h0c47, 8'h00, 1, 4);
		txn(8'h07, RD, 8'h02, 16'h0252, 8'h03);
		txn(8'h07, RD, 8'h02, 16'h0251, 8'h00, 1, 4);
		$display("done decode");
		txn(8'h07, RD, 8'h03, 16'h0000, 8'hff, 0, 0, 1);
		txn(8'h07, RD, 8'h82, 16'h0050, 8'hff, 0, 0, 1);
		txn(8'h07, RD, 8'h82, 16'h0050, 8'h00, 1);
		txn(8'h03, RD, 8'h82, 16'h0050, 8'hff);
		txn(8'h9c, RD, 8'h82, 16'h0050, 8'hff);
		$display("done link faults");
		exec_dly = 1500;
		peek = 1;
		txn(8'h07, RD, 8'h82, 16'h0050, 8'h00, 1);
		exec_dly = 3;
		peek = 0;
		split = 1;
		txn(8'h07, RD, 8'h82, 16'h0050, 8'h00, 1);
		split = 0;
		$display("done busy");
		pulse(selftest_fail);
		txn(8'h07, RD, 8'h82, 16'h0058, 8'h07);
		txn(8'h07, RD, 8'h82, 16'h0058, 8'h07);
		pulse(selftest_clear);
		txn(8'h07, RD, 8'h82, 16'h0058, 8'h00, 1);
		txn(8'h07, RNG, 8'h00, 16'h0000, 8'h04, 1);
		txn(8'h07, RNG, 8'h00, 16'h0000, 8'h08);
		pulse(health_clear);
		txn(8'h07, RNG, 8'h00, 16'h0000, 8'h00, 1);
		$display("done failures");
		no_rst = 1;
		pulse(idle_sleep);
		repeat (6500) @(negedge mclk);
		txn(8'h07, RD, 8'h82, 16'h0060, 8'hee);
		no_rst = 0;
		txn(8'h07, RD, 8'h82, 16'h0060, 8'h00, 1);
		$display("done timer");
		chk("left", 32'h0, eq.size() + cq.size());
		wrap_up();
	end
endmodule // se_status_decode_test
